/* stgc_params.svh */
`ifndef STGC_PARAMS_SVH
`define STGC_PARAMS_SVH
// register byte offsets
`define STGC_OFF_CTRL 12'h000
`define STGC_OFF_GDELAY 12'h004
`define STGC_OFF_GLEN 12'h008
`define STGC_OFF_TOFS 12'h00c
`define STGC_OFF_STAT 12'h010
`define STGC_OFF_SWT 12'h014
// control field positions
`define STGC_CTRL_SRC_LSB 0
`define STGC_CTRL_POL 2
`define STGC_CTRL_GATE_EN 3
`define STGC_CTRL_GMODE 4
`define STGC_CTRL_DCOMP 5
`define STGC_CTRL_SETUP 6
`define STGC_CTRL_ZSPAN 7
// reset values
`define STGC_CTRL_RST 32'h0000_0000
`define STGC_GDELAY_RST 30'h0000_0001
`define STGC_GLEN_RST 30'h0000_0001
`define STGC_TOFS_RST 31'h0000_0000
`define STGC_SWT_RST 32'h0000_0000
// timing: 125 ns tick at 4 ns clock; 125/4 rounded down, never below one
`define STGC_TICK_NS 125
`define STGC_CLK_NS 4
`define STGC_TICK_CYC ((`STGC_TICK_NS / `STGC_CLK_NS) < 1 ? 1 : (`STGC_TICK_NS / `STGC_CLK_NS))
// 100 s in 125 ns ticks
`define STGC_MAX_TICKS 30'd800000000
`define STGC_MIN_TICKS 30'd1
`endif

/* stgc_pkg.sv */
`default_nettype none
package stgc_pkg;
	// trigger source selection
	typedef enum logic [1:0] {
		STGC_SRC_FREE = 2'h0,
		STGC_SRC_VIDEO = 2'h1,
		STGC_SRC_EXT = 2'h2,
		STGC_SRC_IFP = 2'h3
	} stgc_src_t;
	// gate sequencer states, gray along idle->hold->open
	typedef enum logic [1:0] {
		STGC_G_IDLE = 2'b00,
		STGC_G_HOLD = 2'b01,
		STGC_G_OPEN = 2'b11
	} stgc_gst_t;
endpackage
`default_nettype wire

/* stgc_tick_if.sv */
`default_nettype none
// tick carrier between the divider and the main block
interface stgc_tick_if;
	logic tick;
	modport src (output tick);
	modport snk (input tick);
endinterface
`default_nettype wire

/* stgc_tick_gen.sv */
`include "stgc_params.svh"
`default_nettype none
// one-cycle enable every 31 clocks (124 ns), the nominal 125 ns tick
module stgc_tick_gen
	import stgc_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	stgc_tick_if.src tk
);
	localparam int unsigned TC = `STGC_TICK_CYC;
	logic [7:0] cnt_r; // cycle divider
	// ---------------------------------------------
	// divider
	// ---------------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt_r <= 8'h00;
		end else if (cnt_r == 8'(TC - 1)) begin
			cnt_r <= 8'h00;
		end else begin
			cnt_r <= cnt_r + 8'h01;
		end
	end
	assign tk.tick = (cnt_r == 8'(TC - 1));
endmodule
`default_nettype wire

/* stgc_core.sv */
`include "stgc_params.svh"
`default_nettype none
// Overview of operation
// - start on rising or falling edge per polarity
// - polarity for all sources except free run
// - polarity resets to positive
// - sweep halts while gate inactive
// - gate enable paces sweep by gate source
// - gating forces non-gate source to detector
// - level or edge gate mode
// - edge window from length, level from signal
// - level mode ignores and locks gate length
// - level: stop low, resume after delay
// - edge: delay then exactly length, pause
// - gate and trigger polarity are one bit
// - gate delay 125 ns to 100 s
// - gate length 125 ns to 100 s
// - gate delay write updates trigger offset for ext or IFP source only
// - gating also works in zero span
// - setup overrides sweep time, restores after
// - delay compensation enable, resets off
// - trigger offset signed 125 ns steps
// - free run restarts immediately
module stgc_core
	import stgc_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic rear_trigger_input,
	input wire logic ifp_detect,
	input wire logic video_detect,
	input wire logic sweep_done,
	output logic sweep_start,
	output logic sweep_advance,
	output logic gating_indicator,
	output logic delay_comp_en,
	output logic zero_span,
	output logic [31:0] sweep_time_eff,
	output logic [29:0] holdoff_marker,
	output logic [29:0] window_marker
);
	// ---------------------------------------------
	// registers and tick
	// ---------------------------------------------
	stgc_tick_if tk_if ();
	stgc_tick_gen u_tick (
		.clk(clk),
		.nrst(nrst),
		.tk(tk_if)
	);
	logic tick;
	assign tick = tk_if.tick;

	stgc_src_t src_r; // trigger/gate source
	logic edge_sense_select_r; // 0 positive, 1 negative
	logic gate_en_r; // gated sweep on
	logic gmode_edge_r; // 1 edge, 0 level
	logic dcomp_r; // delay compensation
	logic setup_r; // gate setup active
	logic zspan_r; // zero span mode
	logic [29:0] gdelay_r; // gate delay ticks
	logic [29:0] glen_r; // gate length ticks
	logic signed [30:0] tofs_r; // trigger offset ticks
	logic [31:0] swt_r; // normal sweep time
	logic [31:0] swt_setup_r; // temporary sweep time in setup
	logic wr_en;
	logic rd_en;
	logic addr_ok;
	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && penable && !pwrite;
	assign pready = 1'b1; // zero wait states
	always_comb begin
		case (paddr)
			`STGC_OFF_CTRL, `STGC_OFF_GDELAY, `STGC_OFF_GLEN, `STGC_OFF_TOFS,
			`STGC_OFF_STAT, `STGC_OFF_SWT: addr_ok = 1'b1;
			default: addr_ok = 1'b0;
		endcase
	end
	assign pslverr = psel && penable && !addr_ok;

	// clamp a tick count into the legal 125 ns..100 s range
	function automatic logic [29:0] clamp_ticks(input logic [31:0] v);
		logic [29:0] r;
		r = v[29:0];
		if (v > {2'b00, `STGC_MAX_TICKS}) begin
			r = `STGC_MAX_TICKS;
		end else if (v < {2'b00, `STGC_MIN_TICKS}) begin
			r = `STGC_MIN_TICKS;
		end
		return r;
	endfunction

	// ---------------------------------------------
	// control register
	// ---------------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			src_r <= STGC_SRC_FREE;
			edge_sense_select_r <= 1'b0;
			gate_en_r <= 1'b0;
			gmode_edge_r <= 1'b0;
			dcomp_r <= 1'b0;
			setup_r <= 1'b0;
			zspan_r <= 1'b0;
		end else if (wr_en && paddr == `STGC_OFF_CTRL) begin
			// single polarity bit serves trigger and gate alike
			edge_sense_select_r <= pwdata[`STGC_CTRL_POL];
			gate_en_r <= pwdata[`STGC_CTRL_GATE_EN];
			gmode_edge_r <= pwdata[`STGC_CTRL_GMODE];
			dcomp_r <= pwdata[`STGC_CTRL_DCOMP];
			setup_r <= pwdata[`STGC_CTRL_SETUP];
			zspan_r <= pwdata[`STGC_CTRL_ZSPAN];
			// gating needs a shared input: fall back to the detector
			if (pwdata[`STGC_CTRL_GATE_EN] &&
				pwdata[`STGC_CTRL_SRC_LSB+1] == 1'b0) begin
				src_r <= STGC_SRC_IFP;
			end else begin
				src_r <= stgc_src_t'(pwdata[`STGC_CTRL_SRC_LSB+:2]);
			end
		end
	end

	// ---------------------------------------------
	// timing registers
	// ---------------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			gdelay_r <= `STGC_GDELAY_RST;
			glen_r <= `STGC_GLEN_RST;
			tofs_r <= `STGC_TOFS_RST;
		end else if (wr_en) begin
			if (paddr == `STGC_OFF_GDELAY) begin
				gdelay_r <= clamp_ticks(pwdata);
				// shared input: the trigger offset follows the gate delay
				if (src_r == STGC_SRC_EXT || src_r == STGC_SRC_IFP) begin
					tofs_r <= {1'b0, clamp_ticks(pwdata)};
				end
			end
			// length locked while level mode is selected
			if (paddr == `STGC_OFF_GLEN && gmode_edge_r) begin
				glen_r <= clamp_ticks(pwdata);
			end
			if (paddr == `STGC_OFF_TOFS) begin
				// signed, clamped to +-100 s
				if ($signed(pwdata) > $signed({2'b00, `STGC_MAX_TICKS})) begin
					tofs_r <= {1'b0, `STGC_MAX_TICKS};
				end else if ($signed(pwdata) < -$signed({2'b00, `STGC_MAX_TICKS})) begin
					tofs_r <= -$signed({1'b0, `STGC_MAX_TICKS});
				end else begin
					tofs_r <= pwdata[30:0];
				end
			end
		end
	end

	// ---------------------------------------------
	// sweep time with setup override
	// ---------------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			swt_r <= `STGC_SWT_RST;
			swt_setup_r <= `STGC_SWT_RST;
		end else if (wr_en && paddr == `STGC_OFF_SWT) begin
			// during setup only the temporary copy changes
			if (setup_r) begin
				swt_setup_r <= pwdata;
			end else begin
				swt_r <= pwdata;
				swt_setup_r <= pwdata;
			end
		end else if (!setup_r) begin
			swt_setup_r <= swt_r;
		end
	end
	assign sweep_time_eff = setup_r ? swt_setup_r : swt_r;

	// ---------------------------------------------
	// input synchronisation and edge detection
	// ---------------------------------------------
	logic ext_m_r; // first stage, read only by ext_s_r
	logic ext_s_r;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ext_m_r <= 1'b0;
			ext_s_r <= 1'b0;
		end else begin
			ext_m_r <= rear_trigger_input;
			ext_s_r <= ext_m_r;
		end
	end
	logic raw_sig;
	always_comb begin
		case (src_r)
			STGC_SRC_EXT: raw_sig = ext_s_r;
			STGC_SRC_IFP: raw_sig = ifp_detect;
			STGC_SRC_VIDEO: raw_sig = video_detect;
			default: raw_sig = 1'b0;
		endcase
	end
	logic act_sig; // polarity-corrected signal
	logic act_d_r;
	assign act_sig = raw_sig ^ edge_sense_select_r;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			act_d_r <= 1'b0;
		end else begin
			act_d_r <= act_sig;
		end
	end
	logic act_rise;
	assign act_rise = act_sig && !act_d_r;

	// ---------------------------------------------
	// trigger start with offset
	// ---------------------------------------------
	logic armed_r; // waiting for trigger
	logic ofs_busy_r; // offset counting
	logic [29:0] ofs_cnt_r;
	logic start_now;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			armed_r <= 1'b1;
			ofs_busy_r <= 1'b0;
			ofs_cnt_r <= 30'h0;
		end else if (sweep_done) begin
			armed_r <= 1'b1;
			ofs_busy_r <= 1'b0;
		end else if (armed_r && src_r != STGC_SRC_FREE && act_rise) begin
			armed_r <= 1'b0;
			// negative offsets act as zero here; pretrigger is upstream
			if (!tofs_r[30] && tofs_r != 31'h0) begin
				ofs_busy_r <= 1'b1;
				ofs_cnt_r <= tofs_r[29:0];
			end
		end else if (armed_r && src_r == STGC_SRC_FREE) begin
			armed_r <= 1'b0;
		end else if (ofs_busy_r && tick) begin
			ofs_cnt_r <= ofs_cnt_r - 30'h1;
			if (ofs_cnt_r == 30'h1) begin
				ofs_busy_r <= 1'b0;
			end
		end
	end
	// start pulse: immediate when free running or offset zero
	assign start_now = armed_r && !sweep_done &&
		((src_r == STGC_SRC_FREE) ||
		(act_rise && (tofs_r[30] || tofs_r == 31'h0)));
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sweep_start <= 1'b0;
		end else begin
			sweep_start <= start_now || (ofs_busy_r && tick && ofs_cnt_r == 30'h1);
		end
	end

	// ---------------------------------------------
	// gate sequencer
	// ---------------------------------------------
	stgc_gst_t gst_r;
	logic [29:0] gcnt_r; // delay or length down-counter
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			gst_r <= STGC_G_IDLE;
			gcnt_r <= 30'h0;
		end else if (!gate_en_r) begin
			gst_r <= STGC_G_IDLE;
		end else begin
			case (gst_r)
				STGC_G_IDLE: begin
					if (act_rise) begin
						gst_r <= STGC_G_HOLD;
						gcnt_r <= gdelay_r;
					end
				end
				STGC_G_HOLD: begin
					// level mode: a drop during the delay aborts it
					if (!gmode_edge_r && !act_sig) begin
						gst_r <= STGC_G_IDLE;
					end else if (tick) begin
						if (gcnt_r == 30'h1) begin
							gst_r <= STGC_G_OPEN;
							gcnt_r <= glen_r;
						end else begin
							gcnt_r <= gcnt_r - 30'h1;
						end
					end
				end
				STGC_G_OPEN: begin
					if (gmode_edge_r) begin
						if (tick) begin
							if (gcnt_r == 30'h1) begin
								gst_r <= STGC_G_IDLE;
							end else begin
								gcnt_r <= gcnt_r - 30'h1;
							end
						end
					end else if (!act_sig) begin
						gst_r <= STGC_G_IDLE;
					end
				end
				default: gst_r <= STGC_G_IDLE;
			endcase
		end
	end
	// sweep and zero-span sampling proceed only in an open window while gating is on
	assign sweep_advance = !gate_en_r || (gst_r == STGC_G_OPEN);
	assign gating_indicator = gate_en_r;
	assign delay_comp_en = dcomp_r;
	assign zero_span = zspan_r;
	assign holdoff_marker = gdelay_r;
	assign window_marker = glen_r;

	// ---------------------------------------------
	// read mux
	// ---------------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			prdata <= 32'h0;
		end else if (psel && !penable && !pwrite) begin
			case (paddr)
				`STGC_OFF_CTRL: prdata <= {24'h0, zspan_r, setup_r, dcomp_r, gmode_edge_r,
					gate_en_r, edge_sense_select_r, src_r};
				`STGC_OFF_GDELAY: prdata <= {2'b00, gdelay_r};
				`STGC_OFF_GLEN: prdata <= {2'b00, glen_r};
				`STGC_OFF_TOFS: prdata <= {tofs_r[30], tofs_r};
				`STGC_OFF_STAT: prdata <= {27'h0, ofs_busy_r, armed_r, ext_s_r, gst_r};
				`STGC_OFF_SWT: prdata <= sweep_time_eff;
				default: prdata <= 32'h0;
			endcase
		end
	end
	logic unused_rd;
	assign unused_rd = rd_en;
endmodule
`default_nettype wire

/* stgc_burst_src.sv */
`default_nettype none
// ------------------------------
// burst gate source on the rear input
// ------------------------------
module stgc_burst_src #(
	parameter int ON_CYC = 10, // active part of each burst
	parameter int PER_CYC = 400 // burst repetition period
) (
	input wire logic clk,
	input wire logic run, // bursts repeat while high
	input wire logic idle_lvl, // steady level outside bursts
	output logic gate_out
);
	timeunit 1ns;
	timeprecision 1ps;
	int ph_r; // phase inside the period
	// phase restarts when bursts stop, so the first edge comes at once
	always_ff @(posedge clk) begin
		if (!run || ph_r == PER_CYC - 1) begin
			ph_r <= 0;
		end else begin
			ph_r <= ph_r + 1;
		end
	end
	assign gate_out = run ? (ph_r < ON_CYC) : idle_lvl;
endmodule
`default_nettype wire

/* stgc_core_chk.sv */
`include "stgc_params.svh"
`default_nettype none
// ------------------------------
// gate control checker
// ------------------------------
module stgc_core_chk (
	input wire logic clk,
	input wire logic nrst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic rear_trigger_input,
	input wire logic sweep_done,
	input wire logic sweep_start,
	input wire logic sweep_advance,
	input wire logic gating_indicator,
	input wire logic delay_comp_en,
	input wire logic [29:0] holdoff_marker,
	input wire logic [29:0] window_marker
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] ctrl_r; // control word mirror
	logic [15:0] hi_r, run_r; // gate-active time, advance run length
	logic shut_r; // gate seen closed in level mode
	logic wr_ctrl, g, lvl, edg;
	assign wr_ctrl = psel && penable && pwrite && paddr == `STGC_OFF_CTRL;
	assign g = rear_trigger_input ^ ctrl_r[2]; // gate shares the trigger polarity bit
	assign lvl = ctrl_r[4:3] == 2'h1 && ctrl_r[1:0] == 2'h2;
	assign edg = ctrl_r[4:3] == 2'h3 && ctrl_r[1:0] == 2'h2;
	// gate enable moves a non-gate source onto the detector
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ctrl_r <= 8'h00;
		end else if (wr_ctrl) begin
			ctrl_r <= {pwdata[7:2], pwdata[3] && !pwdata[1] ? 2'h3 : pwdata[1:0]};
		end
	end
	// hi_r saturates so a long wait never wraps into a false pass
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			hi_r <= 16'h0000;
			run_r <= 16'h0000;
			shut_r <= 1'b0;
		end else begin
			hi_r <= (lvl && !g) ? 16'h0000 : hi_r + {15'h0000, hi_r != 16'hffff};
			run_r <= (edg && sweep_advance) ? run_r + 16'h0001 : 16'h0000;
			shut_r <= lvl && (shut_r || !g);
		end
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);
	no_gate_adv_a: assert property (
		!gating_indicator |-> sweep_advance) else $error("advance low without gating");
	gate_flag_a: assert property (
		wr_ctrl |=> gating_indicator == $past(pwdata[3])) else $error("gate flag wrong");
	dcomp_flag_a: assert property (
		wr_ctrl |=> delay_comp_en == $past(pwdata[5])) else $error("delay comp wrong");
	lvl_stop_a: assert property (
		(lvl && !g) [*5] |-> !sweep_advance) else $error("advance with gate inactive");
	lvl_early_a: assert property (
		lvl && g && shut_r && hi_r < `STGC_TICK_CYC * (holdoff_marker - 1) |-> !sweep_advance)
		else $error("resumed before gate delay");
	lvl_late_a: assert property (
		lvl && g && shut_r && hi_r > `STGC_TICK_CYC * (holdoff_marker + 1) + 10 |-> sweep_advance)
		else $error("not resumed after gate delay");
	edge_len_a: assert property (
		edg && $past(edg) && $fell(sweep_advance) |-> run_r >= `STGC_TICK_CYC * (window_marker - 1)
		&& run_r <= `STGC_TICK_CYC * (window_marker + 1)) else $error("gate window length wrong");
	free_run_a: assert property (
		ctrl_r[1:0] == 2'h0 && sweep_done |-> ##[1:4] sweep_start) else $error("no free restart");
	cover property (edg && $fell(sweep_advance));
	cover property (lvl && shut_r && g && sweep_advance);
	cover property (ctrl_r[1:0] == 2'h0 && sweep_start);
endmodule
bind stgc_core stgc_core_chk i_stgc_core_chk (
	.clk(clk),
	.nrst(nrst),
	.psel(psel),
	.penable(penable),
	.pwrite(pwrite),
	.paddr(paddr),
	.pwdata(pwdata),
	.rear_trigger_input(rear_trigger_input),
	.sweep_done(sweep_done),
	.sweep_start(sweep_start),
	.sweep_advance(sweep_advance),
	.gating_indicator(gating_indicator),
	.delay_comp_en(delay_comp_en),
	.holdoff_marker(holdoff_marker),
	.window_marker(window_marker)
);
`default_nettype wire

/* tb.sv */
`include "stgc_params.svh"
`default_nettype none
// ------------------------------
// gate control testbench
// ------------------------------
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, nrst, psel, penable, pwrite, sweep_done, video_detect, run, idle_lvl;
	logic pready, pslverr, serr, sweep_start, sweep_advance, gating_indicator;
	logic delay_comp_en, zero_span, rear_trigger_input;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q, sweep_time_eff;
	logic [29:0] holdoff_marker, window_marker;
	int mismatches = 0, num_checks = 0, n;
	// one line feeds both gate sources
	stgc_core i_stgc_core (
		.clk(clk),
		.nrst(nrst),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.rear_trigger_input(rear_trigger_input),
		.ifp_detect(rear_trigger_input),
		.video_detect(video_detect),
		.sweep_done(sweep_done),
		.sweep_start(sweep_start),
		.sweep_advance(sweep_advance),
		.gating_indicator(gating_indicator),
		.delay_comp_en(delay_comp_en),
		.zero_span(zero_span),
		.sweep_time_eff(sweep_time_eff),
		.holdoff_marker(holdoff_marker),
		.window_marker(window_marker)
	);
	stgc_burst_src i_stgc_burst_src (.clk(clk), .run(run), .idle_lvl(idle_lvl),
		.gate_out(rear_trigger_input));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// setup, access until pready, then one idle cycle
	task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
		int k;
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		for (k = 0; k < 50; k++) begin
			@(posedge clk);
			if (pready === 1'b1) break;
		end
		if (k == 50) begin
			mismatches++;
			print_verdict();
		end
		q = prdata;
		serr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(a, 1'b1, d);
	endtask
	task automatic rdc(input logic [11:0] a, input logic [31:0] e);
		apb(a, 1'b0, 32'h0);
		chk(q, e);
	endtask
	task automatic done_pulse();
		sweep_done <= 1'b1;
		@(posedge clk);
		sweep_done <= 1'b0;
	endtask
	// looks 40 cycles for a sweep start
	task automatic wait_start(input logic e);
		logic s;
		s = 1'b0;
		repeat (40) begin
			@(posedge clk);
			s = s | sweep_start;
		end
		chk({31'h0, s}, {31'h0, e});
	endtask
	initial begin
		{nrst, psel, penable, pwrite, sweep_done, video_detect, run, idle_lvl} = 8'h00;
		{paddr, pwdata} = 44'h0;
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		// reset values; status is idle since free run has already started
		for (int i = 0; i < 6; i++) begin
			rdc(12'(4 * i), {31'h0, i == 1 || i == 2});
		end
		apb(12'h020, 1'b0, 32'h0);
		chk(q, 32'h0);
		chk({31'h0, serr}, 32'h1);
		wr(`STGC_OFF_CTRL, 32'h08);
		rdc(`STGC_OFF_CTRL, 32'h0b);
		chk({31'h0, gating_indicator}, 32'h1);
		wr(`STGC_OFF_CTRL, 32'h09);
		rdc(`STGC_OFF_CTRL, 32'h0b);
		wr(`STGC_OFF_CTRL, 32'h02);
		wr(`STGC_OFF_GDELAY, 32'h3);
		rdc(`STGC_OFF_TOFS, 32'h3);
		wr(`STGC_OFF_GDELAY, 32'h0);
		rdc(`STGC_OFF_GDELAY, 32'h1);
		wr(`STGC_OFF_GDELAY, 32'h3fff_ffff);
		rdc(`STGC_OFF_GDELAY, {2'h0, `STGC_MAX_TICKS});
		wr(`STGC_OFF_GDELAY, 32'h3);
		// level gating: closed while low, reopens three ticks after rising
		wr(`STGC_OFF_CTRL, 32'h0a);
		repeat (10) @(posedge clk);
		chk({31'h0, sweep_advance}, 32'h0);
		idle_lvl <= 1'b1;
		repeat (40) @(posedge clk);
		chk({31'h0, sweep_advance}, 32'h0);
		repeat (110) @(posedge clk);
		chk({31'h0, sweep_advance}, 32'h1);
		wr(`STGC_OFF_CTRL, 32'h0e);
		repeat (10) @(posedge clk);
		chk({31'h0, sweep_advance}, 32'h0);
		wr(`STGC_OFF_GLEN, 32'h5);
		rdc(`STGC_OFF_GLEN, 32'h1);
		// edge gating: two bursts, each opens a two-tick window
		// gate off first, so the idle drop is never seen as a gate edge
		wr(`STGC_OFF_CTRL, 32'h02);
		idle_lvl <= 1'b0;
		wr(`STGC_OFF_CTRL, 32'h1a);
		wr(`STGC_OFF_GLEN, 32'h2);
		rdc(`STGC_OFF_GLEN, 32'h2);
		run <= 1'b1;
		n = 0;
		repeat (800) begin
			@(posedge clk);
			n += sweep_advance;
		end
		run <= 1'b0;
		chk(32'(n), 32'(4 * `STGC_TICK_CYC));
		// trigger edges under both polarities
		wr(`STGC_OFF_CTRL, 32'h02);
		wr(`STGC_OFF_TOFS, 32'hffff_ffff);
		rdc(`STGC_OFF_TOFS, 32'hffff_ffff);
		wr(`STGC_OFF_TOFS, 32'h0);
		done_pulse();
		idle_lvl <= 1'b1;
		wait_start(1'b1);
		done_pulse();
		wr(`STGC_OFF_CTRL, 32'h06);
		idle_lvl <= 1'b0;
		wait_start(1'b1);
		done_pulse();
		idle_lvl <= 1'b1;
		wait_start(1'b0);
		// video detector under both polarities
		wr(`STGC_OFF_CTRL, 32'h01);
		video_detect <= 1'b1;
		wait_start(1'b1);
		done_pulse();
		wr(`STGC_OFF_CTRL, 32'h05);
		video_detect <= 1'b0;
		wait_start(1'b1);
		// free run with setup, compensation and zero span
		wr(`STGC_OFF_SWT, 32'h64);
		wr(`STGC_OFF_CTRL, 32'he0);
		chk({30'h0, delay_comp_en, zero_span}, 32'h3);
		done_pulse();
		wait_start(1'b1);
		wr(`STGC_OFF_SWT, 32'h5);
		chk(sweep_time_eff, 32'h5);
		wr(`STGC_OFF_CTRL, 32'h0);
		rdc(`STGC_OFF_SWT, 32'h64);
		chk(sweep_time_eff, 32'h64);
		print_verdict();
	end
endmodule
`default_nettype wire
